// ---- rtl/lclk_pkg.sv ----
// lclk_pkg: register map, field layout and constants of the lcd clock and ladder block
package lclk_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_PRESCALE = 8'h04;
  localparam logic [7:0] OFS_LADDER   = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_DATA0    = 8'h10;
  localparam int         NUM_DATA     = 4;
  localparam int         ADR_W        = 8;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_SRC_LO    = 0;  // clock source select, 2 bits
  localparam int CTL_BIAS_LO   = 2;  // bias type, 2 bits
  localparam int CTL_HALF_BIAS = 4;  // half_bias_select
  localparam int CTL_ENABLE    = 7;  // module enable
  localparam int PS_SEL_LO     = 0;  // frame_prescale_sel, 4 bits
  localparam int LAD_AT_LO     = 0;  // ladder_a_time, 3 bits
  localparam int LAD_BP_LO     = 4;  // mode b power, 2 bits
  localparam int LAD_AP_LO     = 6;  // mode a power, 2 bits

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_LADDER   = 8'h00;
  localparam logic [7:0] RST_DATA     = 8'h00;

  // ****************************************************************
  // timing counts
  // ****************************************************************
  localparam int         SYS_DIV      = 256;  // fixed system clock divider
  localparam logic [7:0] SYS_DIV_LAST = 8'(SYS_DIV - 1);
  localparam logic [4:0] SEG_CNT_LAST = 5'h1F; // 32 source ticks per segment time

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    LCLK_SRC_SYS = 2'h0,
    LCLK_SRC_T1  = 2'h1,
    LCLK_SRC_LF  = 2'h2
  } lclk_src_e;

  typedef enum logic [1:0] {
    LCLK_BIAS_STATIC = 2'h0,
    LCLK_BIAS_HALF   = 2'h1,
    LCLK_BIAS_THIRD  = 2'h2
  } lclk_bias_e;

  // ladder power: 00 off/disconnected, 01 low, 10 medium, 11 high
  localparam logic [1:0] PWR_OFF = 2'h0;

endpackage

// ---- rtl/lclk_prescale.sv ----
// lclk_prescale: 4-bit frame prescaler counting selected source ticks
`timescale 1ns/100ps
module lclk_prescale
  import lclk_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic [3:0] ratio,
  output logic            frame_pulse
);

  logic [3:0] cnt_q, cnt_d;
  logic       pulse_q, pulse_d;

  // divide by ratio+1; counter is internal only
  always_comb begin
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (tick) begin
      if (cnt_q >= ratio) begin
        cnt_d   = 4'h0;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q   <= 4'h0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign frame_pulse = pulse_q;

endmodule

// ---- rtl/lclk_ladder.sv ----
// lclk_ladder: a/b ladder power mode timing from the 5-bit segment counter
`timescale 1ns/100ps
module lclk_ladder
  import lclk_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       active,
  input  wire logic [2:0] a_time,
  input  wire logic [1:0] a_pwr,
  input  wire logic [1:0] b_pwr,
  output logic [1:0]      power,
  output logic            seg_edge
);

  logic [4:0] seg_cnt_q, seg_cnt_d;
  logic [1:0] pwr_q, pwr_d;
  logic       edge_q, edge_d;

  // segment counter wraps each segment time; mode a while count below a_time
  always_comb begin
    seg_cnt_d = seg_cnt_q;
    edge_d    = 1'b0;
    if (!active) begin
      seg_cnt_d = 5'h00;
    end else if (tick) begin
      seg_cnt_d = seg_cnt_q + 5'h01;
      if (seg_cnt_q == SEG_CNT_LAST) begin
        edge_d = 1'b1;
      end
    end
    if (!active) begin
      pwr_d = PWR_OFF;
    end else if (seg_cnt_d < {2'h0, a_time}) begin
      pwr_d = a_pwr;
    end else begin
      pwr_d = b_pwr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      seg_cnt_q <= 5'h00;
      pwr_q     <= PWR_OFF;
      edge_q    <= 1'b0;
    end else begin
      seg_cnt_q <= seg_cnt_d;
      pwr_q     <= pwr_d;
      edge_q    <= edge_d;
    end
  end

  assign power    = pwr_q;
  assign seg_edge = edge_q;

endmodule

// ---- rtl/lclk_top.sv ----
// lclk_top: lcd clock source selection, prescaler, bias and ladder control
// Behaviour
// - pixel data bit 1 drives pixel dark, 0 leaves it clear.
// - two-bit field picks system/256, timer1 oscillator or low-frequency oscillator.
// - divide-by-256 on system clock is fixed; only prescaler adjusts frame rate.
// - 4-bit prescaler divides selected clock 1:1 to 1:16; counter hidden.
// - timer1 or low-frequency source keeps lcd logic running during sleep.
// - static, half and third bias types are supported.
// - half bias select shorts the middle ladder resistor.
// - ladder offers low, medium and high power modes.
// - ladder disabled disconnects all sections for external bias.
// - lcd inactive forces the ladder off regardless of power mode.
// - ladder register holds modes a and b; a starts each transition.
// - mode b holds for the rest of each segment time.
// - 3-bit a-time sets mode a length; zero means never.
// - a/b interval timed from 5-bit count of source ticks per segment.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module lclk_top
  import lclk_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     sleep,
  input  wire logic                     timer1_tick,
  input  wire logic                     lf_osc_tick,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [lclk_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          wb_err_o,
  output logic      [31:0]              pixel_on_bit,
  output logic                          frame_clk,
  output logic                          lcd_active_flag,
  output logic      [1:0]               bias_type,
  output logic                          ladder_short_mid,
  output logic      [1:0]               ladder_power,
  output logic                          ladder_connect
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  ps_q, ps_d;
  logic [7:0]  lad_q, lad_d;
  logic [7:0]  data_q [NUM_DATA];
  logic [7:0]  data_d [NUM_DATA];
  logic [31:0] rdat_q, rdat_d;
  logic        ack_q, ack_d;
  logic        err_q, err_d;
  logic [7:0]  div_q, div_d;
  logic        tick_q, tick_d;
  logic        fclk_q, fclk_d;
  logic        act_q, act_d;
  logic [1:0]  bias_q, bias_d;
  logic        short_q, short_d;
  logic        conn_q, conn_d;
  logic [31:0] pix_q;
  logic        frame_pulse;
  logic [1:0]  lad_pwr;

  // returns data register index for an address, or NUM_DATA when not a data slot
  function automatic int data_index(input logic [ADR_W-1:0] adr);
    int idx;
    idx = NUM_DATA;
    for (int i = 0; i < NUM_DATA; i++) begin
      if (adr == OFS_DATA0 + ADR_W'(4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic req;
  logic hit;
  int   didx;

  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;

  // one-wait-state answer; writes honour byte lane 0, reads zero-extend
  always_comb begin
    ctl_d  = ctl_q;
    ps_d   = ps_q;
    lad_d  = lad_q;
    for (int i = 0; i < NUM_DATA; i++) begin
      data_d[i] = data_q[i];
    end
    rdat_d = 32'h0000_0000;
    ack_d  = 1'b0;
    err_d  = 1'b0;
    hit    = 1'b1;
    didx   = data_index(wb_adr_i);
    if (req) begin
      case (wb_adr_i)
        OFS_CONTROL:  rdat_d = {24'h00_0000, ctl_q};
        OFS_PRESCALE: rdat_d = {24'h00_0000, ps_q};
        OFS_LADDER:   rdat_d = {24'h00_0000, lad_q};
        OFS_STATUS:   rdat_d = {31'h0000_0000, act_q};
        default: begin
          if (didx < NUM_DATA) begin
            rdat_d = {24'h00_0000, data_q[didx]};
          end else begin
            hit = 1'b0;
          end
        end
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          OFS_CONTROL:  ctl_d = wb_dat_i[7:0] & 8'h9F;
          OFS_PRESCALE: ps_d  = wb_dat_i[7:0] & 8'h0F;
          OFS_LADDER:   lad_d = wb_dat_i[7:0] & 8'hF7;
          default: begin
            if (didx < NUM_DATA) begin
              data_d[didx] = wb_dat_i[7:0];
            end
          end
        endcase
      end
      if (!wb_we_i || hit) begin
        rdat_d = wb_we_i ? 32'h0000_0000 : rdat_d;
      end
      ack_d = hit;
      err_d = !hit;
    end
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  logic      src_tick;
  lclk_src_e src_sel;

  assign src_sel = lclk_src_e'(ctl_q[CTL_SRC_LO +: 2]);

  // fixed /256 of mclk; sleep stops only the system source
  always_comb begin
    div_d    = (div_q == SYS_DIV_LAST) ? 8'h00 : div_q + 8'h01;
    src_tick = 1'b0;
    case (src_sel)
      LCLK_SRC_SYS: src_tick = (div_q == SYS_DIV_LAST) && !sleep;
      LCLK_SRC_T1:  src_tick = timer1_tick;
      LCLK_SRC_LF:  src_tick = lf_osc_tick;
      default:      src_tick = 1'b0;
    endcase
    tick_d = src_tick && ctl_q[CTL_ENABLE];
  end

  // ****************************************************************
  // prescaler and ladder timing
  // ****************************************************************
  lclk_prescale u_prescale (
    .mclk        (mclk),
    .rst         (rst),
    .tick        (tick_q),
    .ratio       (ps_q[PS_SEL_LO +: 4]),
    .frame_pulse (frame_pulse)
  );

  lclk_ladder u_ladder (
    .mclk     (mclk),
    .rst      (rst),
    .tick     (tick_q),
    .active   (act_q),
    .a_time   (lad_q[LAD_AT_LO +: 3]),
    .a_pwr    (lad_q[LAD_AP_LO +: 2]),
    .b_pwr    (lad_q[LAD_BP_LO +: 2]),
    .power    (lad_pwr),
    .seg_edge ()
  );

  // ****************************************************************
  // bias and output state
  // ****************************************************************
  always_comb begin
    fclk_d  = frame_pulse ? !fclk_q : fclk_q;
    act_d   = ctl_q[CTL_ENABLE] && !(sleep && src_sel == LCLK_SRC_SYS);
    bias_d  = ctl_q[CTL_BIAS_LO +: 2];
    short_d = ctl_q[CTL_HALF_BIAS];
    conn_d  = lad_pwr != PWR_OFF;
  end

  // pixel outputs mirror data registers
  generate
    for (genvar g = 0; g < NUM_DATA; g++) begin : g_pix
      always_ff @(posedge mclk) begin
        if (rst) begin
          pix_q[8*g +: 8] <= RST_DATA;
        end else begin
          pix_q[8*g +: 8] <= data_q[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_q   <= RST_CONTROL;
      ps_q    <= RST_PRESCALE;
      lad_q   <= RST_LADDER;
      for (int i = 0; i < NUM_DATA; i++) begin
        data_q[i] <= RST_DATA;
      end
      rdat_q  <= 32'h0000_0000;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      div_q   <= 8'h00;
      tick_q  <= 1'b0;
      fclk_q  <= 1'b0;
      act_q   <= 1'b0;
      bias_q  <= 2'h0;
      short_q <= 1'b0;
      conn_q  <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      ps_q    <= ps_d;
      lad_q   <= lad_d;
      for (int i = 0; i < NUM_DATA; i++) begin
        data_q[i] <= data_d[i];
      end
      rdat_q  <= rdat_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
      div_q   <= div_d;
      tick_q  <= tick_d;
      fclk_q  <= fclk_d;
      act_q   <= act_d;
      bias_q  <= bias_d;
      short_q <= short_d;
      conn_q  <= conn_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_dat_o         = rdat_q;
  assign wb_ack_o         = ack_q;
  assign wb_err_o         = err_q;
  assign pixel_on_bit     = pix_q;
  assign frame_clk        = fclk_q;
  assign lcd_active_flag  = act_q;
  assign bias_type        = bias_q;
  assign ladder_short_mid = short_q;
  assign ladder_power     = lad_pwr;
  assign ladder_connect   = conn_q;

endmodule

// ---- sim/lclk_glass.sv ----
// lclk_glass: behavioural lcd glass seen from the segment and common side
`timescale 1ns/100ps
module lclk_glass (
  input  wire logic        mclk,
  input  wire logic        frame_clk,
  input  wire logic [31:0] pixel_on_bit,
  output int               edges,
  output logic [31:0]      dark
);
  logic prev_q = 1'b0;
  initial edges = 0;
  // each set bit darkens its pixel
  assign dark = pixel_on_bit;
  // count frame clock toggles seen by the glass
  always @(posedge mclk) begin
    prev_q <= frame_clk;
    if (frame_clk !== prev_q) edges <= edges + 1;
  end
endmodule

// ---- sim/lclk_top_properties.sv ----
// lclk_top_properties: bus and output checks on the lclk_top ports
`timescale 1ns/100ps
module lclk_top_properties
  import lclk_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [31:0] pixel_on_bit,
  input wire logic        lcd_active_flag,
  input wire logic [1:0]  ladder_power,
  input wire logic        ladder_connect
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       req;
  logic       mapped;
  logic       wr0;
  logic [7:0] pix_d;
  logic [7:0] pix_q;
  // request taken, address decode
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i < 8'h20);
  assign wr0    = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_DATA0);
  // last byte written to pixel register 0
  always_comb begin
    pix_d = wr0 ? wb_dat_i[7:0] : pix_q;
  end
  always_ff @(posedge mclk) begin
    pix_q <= rst ? RST_DATA : pix_d;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_bus_answer: assert property (req |=> (wb_ack_o != wb_err_o))
    else $error("no single answer to a taken request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");
  a_write_zero_data: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("read data nonzero on write");
  a_upper_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits nonzero");
  a_pixel_follow: assert property (wr0 |-> ##3 pixel_on_bit[7:0] == pix_q)
    else $error("pixel bits differ from written data");
  a_ladder_off_idle: assert property (!lcd_active_flag [*3] |-> ladder_power == PWR_OFF)
    else $error("ladder powered while inactive");
  a_connect_power: assert property (ladder_connect == ($past(ladder_power) != PWR_OFF))
    else $error("ladder connect does not match power");
endmodule
bind lclk_top lclk_top_properties lclk_top_properties_i (.mclk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
  .wb_err_o, .pixel_on_bit, .lcd_active_flag, .ladder_power, .ladder_connect);

// ---- sim/tb_lclk_top.sv ----
// tb_lclk_top: register level tests of the lcd clock and ladder block
`timescale 1ns/100ps
module tb_lclk_top;
  import lclk_pkg::*;
  logic        mclk = 0, rst = 1, sleep = 0, t1 = 0, lf = 0, cyc = 0, stb = 0, we = 0, e;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0, rd, dat_o, pix;
  logic        ack, err, fclk, act, smid, conn;
  logic [1:0]  bias, pwr;
  int          failures = 0, check_count = 0, edges, e0, n;
  int          n_ps[3] = '{0, 5, 15};
  int          n_at[3] = '{0, 3, 7};
  lclk_top lclk_top_i (.mclk(mclk), .rst(rst), .sleep(sleep), .timer1_tick(t1),
    .lf_osc_tick(lf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .pixel_on_bit(pix), .frame_clk(fclk), .lcd_active_flag(act), .bias_type(bias),
    .ladder_short_mid(smid), .ladder_power(pwr), .ladder_connect(conn));
  lclk_glass lclk_glass_i (.mclk(mclk), .frame_clk(fclk), .pixel_on_bit(pix),
    .edges(edges), .dark());
  // clock generator, 100 ns period
  initial forever #50 mclk = ~mclk;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
    // ack or err ends the wait for the answer; the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = dat_o;
    e = err;
    cyc <= 0; stb <= 0; we <= 0;
    chk(ack ^ err, 1);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] x);
    wb(0, a, 0, 4'hF);
    chk(rd, x);
    chk(e, 0);
  endtask
  task automatic ticks(int nt, logic a, logic b);
    repeat (nt) begin
      @(posedge mclk); t1 <= a; lf <= b;
      @(posedge mclk); t1 <= 0; lf <= 0;
      // source tick reaches the glass count three edges after it is sampled
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    final_report;
  end
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 0;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 0);
    wb(0, 8'h20, 0, 4'hF); chk(e, 1);
    wb(1, 8'h02, 1, 4'hF); chk(e, 1);
    for (int i = 0; i < 4; i++) wb(1, OFS_DATA0 + 8'(i * 4), 32'h5A + i, 4'hF);
    wb(1, OFS_DATA0, 32'hFF, 4'h0);
    repeat (3) @(posedge mclk);
    chk(pix, 32'h5D5C5B5A);
    rdc(OFS_DATA0, 32'h5A);
    for (int b = 0; b < 3; b++) begin
      wb(1, OFS_CONTROL, 32'((b << 2) | ((b == 1) << 4)), 4'hF);
      repeat (3) @(posedge mclk);
      chk(bias, b);
      chk(smid, b == 1);
    end
    foreach (n_ps[j]) for (int s = 1; s < 3; s++) begin
      wb(1, OFS_CONTROL, 32'h80 | s, 4'hF);
      wb(1, OFS_PRESCALE, n_ps[j], 4'hF);
      rdc(OFS_PRESCALE, n_ps[j]);
      e0 = edges;
      ticks(2 * (n_ps[j] + 1), s == 1, s == 2);
      chk(edges - e0, 2);
      e0 = edges;
      ticks(3, s == 2, s == 1);
      chk(edges - e0, 0);
    end
    wb(1, OFS_CONTROL, 32'h80, 4'hF);
    wb(1, OFS_PRESCALE, 0, 4'hF);
    repeat (600) @(posedge mclk);
    e0 = edges;
    repeat (1024) @(posedge mclk);
    chk(edges - e0, 1024 / SYS_DIV);
    wb(1, OFS_CONTROL, 32'h82, 4'hF);
    foreach (n_at[j]) begin
      wb(1, OFS_LADDER, 32'hD0 | n_at[j], 4'hF);
      n = 0;
      repeat (32) begin
        ticks(1, 0, 1);
        n += (pwr === 2'h3);
      end
      chk(n, n_at[j]);
    end
    for (int b = 0; b < 4; b++) begin
      wb(1, OFS_LADDER, 32'(b << 4), 4'hF);
      ticks(1, 0, 1);
      chk(pwr, b);
      chk(conn, b != 0);
    end
    wb(1, OFS_LADDER, 32'h10, 4'hF);
    sleep <= 1;
    repeat (4) @(posedge mclk);
    chk(act, 1);
    rdc(OFS_STATUS, 1);
    e0 = edges;
    ticks(2, 0, 1);
    chk(edges - e0, 2);
    wb(1, OFS_CONTROL, 32'h80, 4'hF);
    repeat (4) @(posedge mclk);
    chk(act, 0);
    chk(pwr, PWR_OFF);
    rdc(OFS_STATUS, 0);
    e0 = edges;
    repeat (600) @(posedge mclk);
    chk(edges - e0, 0);
    sleep <= 0;
    final_report;
  end
endmodule
